/* rtl/nvcfg_top.sv */
// How it works
// - Address 1001 plus pins, write bit zero.
// - Pointer byte 11h selects this register.
// - Two data bytes; later bytes ignored.
// - Early Stop or Start discards data.
// - Valid write plus Stop starts timed program.
// - Repeated Start discards the write; no program.
// - No programming while busy or locked down; locked allows lock clear only.
// - Locked acks all; busy nacks data bytes.
// - Resolution code picks 9 to 12 bits.
// - Fault code picks one, two, four, six.
// - Polarity bit sets alert active level.
// - Mode bit picks comparator or interrupt.
// - Shutdown bit starts device in shutdown.
// - Lockdown is one-time and blocks all programming, lock clear included.
// - Lockdown outranks the reversible lock.
// - Under lock only lock clear is accepted.
// - Factory value of every field is zero.
// - Reset copies upper byte into config.
// - Fields at fixed bits; others read zero.
// - Copies ignored while program is busy.
`timescale 1ns/10ps
`default_nettype none

module nvcfg_top #(
    parameter int unsigned NV_PROGRAM_CYCLES = nvcfg_pkg::NV_PROGRAM_TIME_US * 1000 / nvcfg_pkg::CLK_PERIOD_NS
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire nvcfg_pkg::nvcfg_link_s i_link,
    input wire logic [2:0] i_addr_pin_bits,
    input wire logic i_factory_init,
    input wire logic i_copy_nv_to_config,
    output logic o_sda_out,
    output logic o_sda_oe_b,
    output logic o_nv_program_busy,
    output nvcfg_pkg::nvcfg_config_s o_config,
    output logic [3:0] o_resolution_bits,
    output logic [7:0] o_conv_time_ms,
    output logic [2:0] o_fault_count,
    output logic o_alert_active_high,
    output logic o_interrupt_mode,
    output logic o_shutdown,
    output logic o_write_protect,
    output logic o_lockdown_active,
    output logic [15:0] o_nv_config
);
    import nvcfg_pkg::*;

    // =====================================================================
    // Decode helpers.
    function automatic logic [7:0] conv_time(input logic [1:0] sel);
        case (sel)
            2'h0: conv_time = CONV_TIME_MS_00;
            2'h1: conv_time = CONV_TIME_MS_01;
            2'h2: conv_time = CONV_TIME_MS_10;
            default: conv_time = CONV_TIME_MS_11;
        endcase
    endfunction : conv_time

    function automatic logic [2:0] fault_count(input logic [1:0] sel);
        case (sel)
            2'h0: fault_count = FAULTS_00;
            2'h1: fault_count = FAULTS_01;
            2'h2: fault_count = FAULTS_10;
            default: fault_count = FAULTS_11;
        endcase
    endfunction : fault_count

    function automatic nvcfg_config_s upper_to_config(input logic [15:0] nv);
        upper_to_config.default_resolution_sel = nv[RES_LSB +: 2];
        upper_to_config.default_fault_queue_sel = nv[FAULT_LSB +: 2];
        upper_to_config.default_alert_polarity = nv[POL_BIT];
        upper_to_config.default_thermostat_mode = nv[MODE_BIT];
        upper_to_config.default_shutdown = nv[SHDN_BIT];
    endfunction : upper_to_config

    // =====================================================================
    // Pin sampling and bus conditions.
    logic scl;
    logic sda;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    nvcfg_pin_sync u_scl_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_pin(i_link.scl),
        .o_level(scl)
    );

    nvcfg_pin_sync u_sda_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_pin(i_link.sda),
        .o_level(sda)
    );

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
        end
    end

    assign scl_rise = scl & ~scl_d_reg;
    assign scl_fall = ~scl & scl_d_reg;
    assign start_cond = scl & scl_d_reg & sda_d_reg & ~sda;
    assign stop_cond = scl & scl_d_reg & ~sda_d_reg & sda;

    // =====================================================================
    // Program cycle timer.
    logic prog_start;
    logic prog_done;
    logic busy;

    nvcfg_prog_timer #(
        .CYCLES((NV_PROGRAM_CYCLES < 1) ? 1 : NV_PROGRAM_CYCLES)
    ) u_prog_timer (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_start(prog_start),
        .o_busy(busy),
        .o_done(prog_done)
    );

    // =====================================================================
    // Serial slave state.
    nvcfg_state_e state_reg;
    nvcfg_state_e state_next;
    nvcfg_state_e after_ack_reg;
    nvcfg_state_e after_ack_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    logic [7:0] lo_reg;
    logic [7:0] lo_next;
    logic [1:0] nbytes_reg;
    logic [1:0] nbytes_next;
    logic sda_low_reg;
    logic sda_low_next;
    logic rd_hi_reg;
    logic rd_hi_next;
    logic mack_reg;
    logic mack_next;
    logic [15:0] pending_reg;
    logic [15:0] pending_next;
    logic [15:0] nv_reg;
    logic [15:0] nv_next;
    logic [15:0] wr_data;
    logic [7:0] tx_byte;

    always_comb begin
        state_next = state_reg;
        after_ack_next = after_ack_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        hi_next = hi_reg;
        lo_next = lo_reg;
        nbytes_next = nbytes_reg;
        sda_low_next = sda_low_reg;
        rd_hi_next = rd_hi_reg;
        mack_next = mack_reg;
        pending_next = pending_reg;
        prog_start = 1'b0;
        wr_data = {hi_reg, lo_reg} & NV_WRITABLE_MASK;
        tx_byte = 8'h00;
        if (start_cond) begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            nbytes_next = 2'h0;
            sda_low_next = 1'b0;
        end else if (stop_cond) begin
            state_next = ST_IDLE;
            sda_low_next = 1'b0;
            nbytes_next = 2'h0;
            if (nbytes_reg == DATA_BYTES && ptr_reg == PTR_NV_CONFIG && !busy) begin
                if (nv_reg[LOCKDOWN_BIT]) begin
                    prog_start = 1'b0;
                end else if (nv_reg[LOCK_BIT]) begin
                    if (!wr_data[LOCK_BIT]) begin
                        pending_next = nv_reg & ~NV_LOCK_MASK;
                        prog_start = 1'b1;
                    end
                end else begin
                    pending_next = wr_data;
                    prog_start = 1'b1;
                end
            end
        end else if (state_reg != ST_IDLE) begin
            if (scl_rise) begin
                case (state_reg)
                    ST_ADDR, ST_PTR, ST_DATA: begin
                        shift_next = {shift_reg[6:0], sda};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    ST_RACK: begin
                        mack_next = ~sda;
                    end
                    default: begin
                        mack_next = mack_reg;
                    end
                endcase
            end else if (scl_fall) begin
                case (state_reg)
                    ST_ADDR: begin
                        if (cnt_reg == BITS_PER_BYTE) begin
                            if (shift_reg[7:1] == {SLAVE_ADDR_HI, i_addr_pin_bits}) begin
                                sda_low_next = 1'b1;
                                state_next = ST_ACK;
                                after_ack_next = shift_reg[0] ? ST_READ : ST_PTR;
                                rd_hi_next = 1'b1;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end
                    end
                    ST_PTR: begin
                        if (cnt_reg == BITS_PER_BYTE) begin
                            ptr_next = shift_reg;
                            sda_low_next = 1'b1;
                            state_next = ST_ACK;
                            after_ack_next = ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (cnt_reg == BITS_PER_BYTE) begin
                            if (busy) begin
                                state_next = ST_IDLE;
                            end else begin
                                sda_low_next = 1'b1;
                                state_next = ST_ACK;
                                after_ack_next = ST_DATA;
                                if (nbytes_reg == 2'h0) begin
                                    hi_next = shift_reg;
                                end
                                if (nbytes_reg == 2'h1) begin
                                    lo_next = shift_reg;
                                end
                                if (nbytes_reg != DATA_BYTES) begin
                                    nbytes_next = nbytes_reg + 2'h1;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        cnt_next = 4'h0;
                        state_next = after_ack_reg;
                        sda_low_next = 1'b0;
                        if (after_ack_reg == ST_READ) begin
                            tx_byte = (ptr_reg == PTR_NV_CONFIG) ? nv_reg[15:8] : 8'h00;
                            sda_low_next = ~tx_byte[7];
                            cnt_next = 4'h1;
                        end
                    end
                    ST_READ: begin
                        tx_byte = (ptr_reg != PTR_NV_CONFIG) ? 8'h00 : (rd_hi_reg ? nv_reg[15:8] : nv_reg[7:0]);
                        if (cnt_reg == BITS_PER_BYTE) begin
                            sda_low_next = 1'b0;
                            state_next = ST_RACK;
                        end else begin
                            sda_low_next = ~tx_byte[3'(3'h7 - cnt_reg[2:0])];
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end
                    ST_RACK: begin
                        if (mack_reg) begin
                            rd_hi_next = ~rd_hi_reg;
                            tx_byte = (ptr_reg != PTR_NV_CONFIG) ? 8'h00 : (rd_hi_reg ? nv_reg[7:0] : nv_reg[15:8]);
                            sda_low_next = ~tx_byte[7];
                            cnt_next = 4'h1;
                            state_next = ST_READ;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                    default: begin
                        state_next = ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
            after_ack_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            hi_reg <= 8'h00;
            lo_reg <= 8'h00;
            nbytes_reg <= 2'h0;
            sda_low_reg <= 1'b0;
            rd_hi_reg <= 1'b1;
            mack_reg <= 1'b0;
            pending_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            after_ack_reg <= after_ack_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            nbytes_reg <= nbytes_next;
            sda_low_reg <= sda_low_next;
            rd_hi_reg <= rd_hi_next;
            mack_reg <= mack_next;
            pending_reg <= pending_next;
        end
    end

    // =====================================================================
    // Nonvolatile storage; it survives reset and is cleared by factory init.
    always_comb begin
        nv_next = nv_reg;
        if (i_factory_init) begin
            nv_next = NV_FACTORY_VALUE;
        end else if (prog_done) begin
            nv_next = pending_reg;
        end
    end

    always_ff @(posedge i_clock) begin
        nv_reg <= nv_next;
    end

    // =====================================================================
    // Volatile configuration loaded from the upper byte.
    nvcfg_config_s config_reg;
    nvcfg_config_s config_next;

    always_comb begin
        config_next = config_reg;
        if (!i_rst_b) begin
            config_next = upper_to_config(nv_reg);
        end else if (i_copy_nv_to_config && !busy) begin
            config_next = upper_to_config(nv_reg);
        end
    end

    always_ff @(posedge i_clock) begin
        config_reg <= config_next;
    end

    // =====================================================================
    // Outputs.
    assign o_sda_out = 1'b0;
    assign o_sda_oe_b = ~sda_low_reg;
    assign o_nv_program_busy = busy;
    assign o_config = config_reg;
    assign o_resolution_bits = RES_BITS_BASE + {2'h0, config_reg.default_resolution_sel};
    assign o_conv_time_ms = conv_time(config_reg.default_resolution_sel);
    assign o_fault_count = fault_count(config_reg.default_fault_queue_sel);
    assign o_alert_active_high = config_reg.default_alert_polarity;
    assign o_interrupt_mode = config_reg.default_thermostat_mode;
    assign o_shutdown = config_reg.default_shutdown;
    assign o_write_protect = nv_reg[LOCKDOWN_BIT] | nv_reg[LOCK_BIT];
    assign o_lockdown_active = nv_reg[LOCKDOWN_BIT];
    assign o_nv_config = nv_reg;

endmodule : nvcfg_top

`default_nettype wire

/* rtl/nvcfg_pkg.sv */
package nvcfg_pkg;

    // =====================================================================
    // Bus addressing.
    localparam logic [3:0] SLAVE_ADDR_HI = 4'h9;
    localparam logic [7:0] PTR_NV_CONFIG = 8'h11;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] DATA_BYTES = 2'h2;

    // =====================================================================
    // Field positions of the nonvolatile default register.
    localparam int RES_LSB = 13;
    localparam int FAULT_LSB = 11;
    localparam int POL_BIT = 10;
    localparam int MODE_BIT = 9;
    localparam int SHDN_BIT = 8;
    localparam int LOCKDOWN_BIT = 2;
    localparam int LOCK_BIT = 1;
    localparam logic [15:0] NV_WRITABLE_MASK = 16'h7f06;
    localparam logic [15:0] NV_LOCK_MASK = 16'h0002;
    localparam logic [15:0] NV_FACTORY_VALUE = 16'h0000;

    // =====================================================================
    // Resolution and fault queue decode.
    localparam logic [3:0] RES_BITS_BASE = 4'h9;
    localparam logic [7:0] CONV_TIME_MS_00 = 8'h19;
    localparam logic [7:0] CONV_TIME_MS_01 = 8'h32;
    localparam logic [7:0] CONV_TIME_MS_10 = 8'h64;
    localparam logic [7:0] CONV_TIME_MS_11 = 8'hc8;
    localparam logic [2:0] FAULTS_00 = 3'h1;
    localparam logic [2:0] FAULTS_01 = 3'h2;
    localparam logic [2:0] FAULTS_10 = 3'h4;
    localparam logic [2:0] FAULTS_11 = 3'h6;

    // =====================================================================
    // Timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int NV_PROGRAM_TIME_US = 5000;

    // =====================================================================
    // Types.
    typedef struct packed {
        logic scl;
        logic sda;
    } nvcfg_link_s;

    typedef struct packed {
        logic [1:0] default_resolution_sel;
        logic [1:0] default_fault_queue_sel;
        logic default_alert_polarity;
        logic default_thermostat_mode;
        logic default_shutdown;
    } nvcfg_config_s;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_PTR = 7'h04,
        ST_DATA = 7'h08,
        ST_ACK = 7'h10,
        ST_READ = 7'h20,
        ST_RACK = 7'h40
    } nvcfg_state_e;

endpackage : nvcfg_pkg

/* rtl/nvcfg_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module nvcfg_pin_sync (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_pin,
    output logic o_level
);
    import nvcfg_pkg::*;

    logic [2:0] chain_reg;
    logic [2:0] chain_next;
    logic level_reg;
    logic level_next;

    // =====================================================================
    // Three stages; the level moves once the last two agree.
    always_comb begin
        chain_next = {chain_reg[1:0], i_pin};
        level_next = level_reg;
        if (chain_reg[1] == chain_reg[2]) begin
            level_next = chain_reg[2];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            chain_reg <= 3'h7;
            level_reg <= 1'b1;
        end else begin
            chain_reg <= chain_next;
            level_reg <= level_next;
        end
    end

    assign o_level = level_reg;

endmodule : nvcfg_pin_sync

`default_nettype wire

/* rtl/nvcfg_prog_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module nvcfg_prog_timer #(
    parameter int unsigned CYCLES = 100000
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    import nvcfg_pkg::*;

    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic busy_reg;
    logic busy_next;

    // =====================================================================
    // Busy stands for exactly CYCLES clocks after a start.
    always_comb begin
        count_next = count_reg;
        busy_next = busy_reg;
        o_done = 1'b0;
        if (busy_reg) begin
            if (count_reg == 32'h0) begin
                busy_next = 1'b0;
                o_done = 1'b1;
            end else begin
                count_next = count_reg - 32'h1;
            end
        end else if (i_start) begin
            busy_next = 1'b1;
            count_next = 32'(CYCLES - 1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            count_reg <= 32'h0;
            busy_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg <= busy_next;
        end
    end

    assign o_busy = busy_reg;

endmodule : nvcfg_prog_timer

`default_nettype wire

/* verif/nvcfg_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Checker of the default register block.
module nvcfg_checker #(
    parameter int unsigned NV_PROGRAM_CYCLES = 20
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_factory_init,
    input wire logic i_copy_nv_to_config,
    input wire logic o_nv_program_busy,
    input wire nvcfg_pkg::nvcfg_config_s o_config,
    input wire logic [3:0] o_resolution_bits,
    input wire logic [7:0] o_conv_time_ms,
    input wire logic [2:0] o_fault_count,
    input wire logic o_write_protect,
    input wire logic o_lockdown_active,
    input wire logic [15:0] o_nv_config
);
    import nvcfg_pkg::*;
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;
    always_comb begin
        busy_cnt_next = o_nv_program_busy ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge i_clock) begin
        busy_cnt_reg <= i_rst_b ? busy_cnt_next : 32'h0;
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    sequence prog_end_s;
        $fell(o_nv_program_busy);
    endsequence
    sequence copy_free_s;
        i_copy_nv_to_config && !o_nv_program_busy;
    endsequence
    prog_length_a: assert property (prog_end_s |-> busy_cnt_reg == NV_PROGRAM_CYCLES)
        else $error("program length wrong");
    res_map_a: assert property (o_resolution_bits == RES_BITS_BASE + 4'(o_config.default_resolution_sel))
        else $error("resolution wrong");
    conv_time_a: assert property (o_conv_time_ms == (CONV_TIME_MS_00 << o_config.default_resolution_sel))
        else $error("conversion time wrong");
    fault_map_a: assert property (o_fault_count == ((o_config.default_fault_queue_sel == 2'h0) ?
        FAULTS_00 : {o_config.default_fault_queue_sel, 1'b0})) else $error("fault count wrong");
    protect_map_a: assert property ({o_write_protect, o_lockdown_active} ==
        {o_nv_config[LOCK_BIT] | o_nv_config[LOCKDOWN_BIT], o_nv_config[LOCKDOWN_BIT]}) else $error("protect wrong");
    lockdown_hold_a: assert property (o_lockdown_active && !i_factory_init |=>
        o_lockdown_active && $stable(o_nv_config)) else $error("lockdown broken");
    nv_quiet_a: assert property (!o_nv_program_busy && !i_factory_init |=> $stable(o_nv_config))
        else $error("stored value changed");
    reserved_zero_a: assert property ((o_nv_config & ~NV_WRITABLE_MASK) == 16'h0000)
        else $error("reserved bit set");
    copy_load_a: assert property (copy_free_s |=> o_config == $past(o_nv_config[14:8]))
        else $error("copy not loaded");
    copy_busy_a: assert property (i_copy_nv_to_config && o_nv_program_busy |=> $stable(o_config))
        else $error("copy taken while busy");
endmodule : nvcfg_checker
bind nvcfg_top nvcfg_checker #(.NV_PROGRAM_CYCLES(NV_PROGRAM_CYCLES)) u_checker (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_factory_init(i_factory_init),
    .i_copy_nv_to_config(i_copy_nv_to_config), .o_nv_program_busy(o_nv_program_busy),
    .o_config(o_config), .o_resolution_bits(o_resolution_bits), .o_conv_time_ms(o_conv_time_ms),
    .o_fault_count(o_fault_count), .o_write_protect(o_write_protect),
    .o_lockdown_active(o_lockdown_active), .o_nv_config(o_nv_config));
`default_nettype wire

/* verif/nvcfg_i2c_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Two-wire bus master model.
module nvcfg_i2c_master (
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda
);
    import nvcfg_pkg::*;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Data moves late in the low phase and is sampled mid high phase.
    task automatic bit_io(input logic b, output logic s);
        #250 o_sda_low = ~b;
        #50 o_scl = 1'b1;
        #50 s = i_sda;
        #50 o_scl = 1'b0;
    endtask : bit_io
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : put_byte
    task automatic xfer(input logic [7:0] addr, input logic [23:0] data, input int n, input logic rep,
                        output logic [4:0] acks);
        logic a;
        acks = 5'h00;
        o_sda_low = 1'b1;
        #200 o_scl = 1'b0;
        put_byte(addr, a);
        acks[4] = a;
        put_byte(PTR_NV_CONFIG, a);
        acks[3] = a;
        for (int i = 0; i < n; i++) begin
            put_byte(data[23 - 8 * i -: 8], a);
            acks[2 - i] = a;
        end
        if (rep) begin
            #250 o_sda_low = 1'b0;
            #50 o_scl = 1'b1;
            #100 o_sda_low = 1'b1;
            #100 o_scl = 1'b0;
        end
        #100 o_sda_low = 1'b1;
        #100 o_scl = 1'b1;
        #100 o_sda_low = 1'b0;
        #400;
    endtask : xfer
endmodule : nvcfg_i2c_master
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Testbench.
module tb_top;
    import nvcfg_pkg::*;
    localparam int NVC = 400;
    localparam logic [7:0] DEV = {SLAVE_ADDR_HI, 3'h5, 1'b0};
    localparam logic [15:0] CONV_TAB [4] = '{16'h0019, 16'h0032, 16'h0064, 16'h00c8};
    localparam logic [15:0] FLT_TAB [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0006};
    logic i_clock, i_rst_b, i_factory_init, i_copy_nv_to_config;
    logic scl, sda_low, sda, so, soe_b, busy, pol, imode, shdn, wp, lkd;
    logic [3:0] res;
    logic [7:0] conv;
    logic [2:0] flt;
    logic [15:0] nv;
    logic [15:0] v;
    nvcfg_config_s cfg;
    int fail_count = 0;
    int check_count = 0;
    assign sda = ~sda_low & (soe_b | so);
    nvcfg_i2c_master u_master (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
    nvcfg_top #(.NV_PROGRAM_CYCLES(NVC)) u_dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_link({scl, sda}), .i_addr_pin_bits(3'h5),
        .i_factory_init(i_factory_init), .i_copy_nv_to_config(i_copy_nv_to_config),
        .o_sda_out(so), .o_sda_oe_b(soe_b), .o_nv_program_busy(busy), .o_config(cfg),
        .o_resolution_bits(res), .o_conv_time_ms(conv), .o_fault_count(flt),
        .o_alert_active_high(pol), .o_interrupt_mode(imode), .o_shutdown(shdn),
        .o_write_protect(wp), .o_lockdown_active(lkd), .o_nv_config(nv));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t ns: got %h, want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic frame(input logic [7:0] a, input logic [23:0] d, input int n, input logic rs,
                         input logic [4:0] exp);
        logic [4:0] acks;
        u_master.xfer(a, d, n, rs, acks);
        chk({11'h0, acks}, {11'h0, exp});
    endtask : frame
    task automatic settle(input logic exp_busy, input logic [15:0] exp_nv);
        int k;
        chk({15'h0, busy}, {15'h0, exp_busy});
        for (k = 0; k < NVC + 50 && busy !== 1'b0; k++) begin
            tick(1);
        end
        if (k == NVC + 50) begin
            fail_count++;
            $display("[ERR] %0t ns: busy stuck", $time);
            give_verdict();
        end
        tick(2);
        chk(nv, exp_nv);
    endtask : settle
    task automatic pulse(input logic copy, input logic rst_b, input int n);
        tick(1);
        i_copy_nv_to_config = copy;
        i_rst_b = rst_b;
        tick(n);
        i_copy_nv_to_config = 1'b0;
        i_rst_b = 1'b1;
        tick(6);
    endtask : pulse
    initial begin
        i_rst_b = 1'b0;
        i_factory_init = 1'b1;
        i_copy_nv_to_config = 1'b0;
        tick(3);
        i_rst_b = 1'b1;
        i_factory_init = 1'b0;
        tick(6);
        chk(nv, 16'h0000);
        chk(16'(cfg), 16'h0000);
        $display("test factory done");
        frame(8'h96, 24'h7f0000, 2, 1'b0, 5'h00);
        settle(1'b0, 16'h0000);
        frame(DEV, 24'hfff9ff, 3, 1'b0, 5'h1f);
        frame(DEV, 24'h230000, 2, 1'b0, 5'h18);
        pulse(1'b1, 1'b1, 1);
        chk(16'(cfg), 16'h0000);
        settle(1'b1, 16'h7f00);
        frame(DEV, 24'h000000, 1, 1'b0, 5'h1c);
        settle(1'b0, 16'h7f00);
        frame(DEV, 24'h000000, 2, 1'b1, 5'h1e);
        settle(1'b0, 16'h7f00);
        $display("test write done");
        for (int c = 0; c < 4; c++) begin
            v = {1'b0, 2'(c), 2'(c), c[0], c[1], ~c[0], 8'h00};
            frame(DEV, {v, 8'h00}, 2, 1'b0, 5'h1e);
            settle(1'b1, v);
            pulse(1'b1, 1'b1, 1);
            chk({12'h0, res}, 16'(9 + c));
            chk({8'h0, conv}, CONV_TAB[c]);
            chk({13'h0, flt}, FLT_TAB[c]);
            chk({13'h0, pol, imode, shdn}, {13'h0, c[0], c[1], ~c[0]});
        end
        frame(DEV, 24'h010000, 2, 1'b0, 5'h1e);
        settle(1'b1, 16'h0100);
        pulse(1'b0, 1'b0, 3);
        chk(16'(cfg), 16'h0001);
        chk({15'h0, shdn}, 16'h0001);
        $display("test fields done");
        frame(DEV, 24'h7f0200, 2, 1'b0, 5'h1e);
        settle(1'b1, 16'h7f02);
        chk({15'h0, wp}, 16'h0001);
        frame(DEV, 24'h000200, 2, 1'b0, 5'h1e);
        settle(1'b0, 16'h7f02);
        frame(DEV, 24'h000000, 2, 1'b0, 5'h1e);
        settle(1'b1, 16'h7f00);
        frame(DEV, 24'h000600, 2, 1'b0, 5'h1e);
        settle(1'b1, 16'h0006);
        frame(DEV, 24'h7f0000, 2, 1'b0, 5'h1e);
        settle(1'b0, 16'h0006);
        $display("test lock done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
